/* File: rtl/sltlog_defines.svh */
// constants of the extended self-test log sector and the log write path
`ifndef SLTLOG_DEFINES_SVH
`define SLTLOG_DEFINES_SVH
`define SLT_SECTOR_BYTES 512
`define SLT_REV_ADDR 0
`define SLT_REV_VALUE 8'h01
`define SLT_IDX_LO_ADDR 2
`define SLT_IDX_HI_ADDR 3
`define SLT_DESC_BASE 4
`define SLT_DESC_LEN 26
`define SLT_NUM_DESC 18
`define SLT_LAST_SUM_ADDR 510
`define SLT_CSUM_ADDR 511
`define SLT_OP_WRITE_LOG 8'h3f
`define SLT_FIFO_DEPTH 32
`define SLT_IDX_RESET 5'h00
`endif

/* File: rtl/sltlog_pkg.sv */
// types of the extended self-test log builder
package sltlog_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DESC = 3'h1,
        ST_HDR = 3'h3,
        ST_SUM = 3'h2,
        ST_CSUM = 3'h6,
        ST_INIT = 3'h7,
        ST_WLOG = 3'h5
    } sltlog_state_e;

    typedef struct packed {
        logic [7:0] lbaLow;
        logic [7:0] status;
        logic [15:0] lifeHours;
        logic [7:0] checkpoint;
        logic [47:0] failLba;
        logic is48;
    } sltlog_test_s;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] logAddr;
        logic [15:0] secOffset;
        logic [15:0] secCount;
    } sltlog_cmd_s;

    typedef struct packed {
        logic valid;
        logic [7:0] logAddr;
        logic [15:0] sector;
        logic [8:0] byteIdx;
        logic [7:0] data;
    } sltlog_beat_s;
endpackage : sltlog_pkg

/* File: rtl/sltlog_top.sv */
// self-test log sector builder with write-log data path and fifo
`timescale 1ns/1ns
`default_nettype none
`include "sltlog_defines.svh"

module sltlog_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SLT_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ready;
    } sltlog_fifo_s;

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    sltlog_fifo_s q, d;
    logic push, pop;

    assign push = inValid & q.ready;
    assign pop = outValid & outReady;
    assign outValid = (q.cnt != '0);
    assign outData = mem[q.rp];
    assign inReady = q.ready;

    always_comb begin
        d = q;
        if (push) begin
            d.wp = q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = q.rp + AW'(1);
        end
        d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        d.ready = (d.cnt < (AW+1)'(DEPTH));
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            q <= '{wp: '0, rp: '0, cnt: '0, ready: 1'b1};
        end else begin
            q <= d;
        end
        if (push) begin
            mem[q.wp] <= inData;
        end
    end

    // back-pressure holds the count when full and not draining
    a_fifo_full_stall: assert property (@(posedge core_clk) disable iff (!nrst)
        (!q.ready && !pop) |=> (q.cnt == $past(q.cnt)))
        else $error("fifo count moved while full and not draining");
endmodule : sltlog_fifo

module sltlog_top
    import sltlog_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic testValid,
    input wire sltlog_test_s testInfo,
    input wire logic cmdValid,
    input wire sltlog_cmd_s cmdInfo,
    input wire logic [7:0] wrData,
    input wire logic wrValid,
    output logic wrReady,
    input wire logic rdEn,
    input wire logic [8:0] rdAddr,
    output logic [7:0] rdData_q,
    output logic rdValid_q,
    output logic idle_q,
    output logic irq_q,
    output sltlog_beat_s beat_q
);
    typedef struct packed {
        sltlog_state_e st;
        logic [4:0] idx;
        logic [9:0] byteCnt;
        logic [15:0] sector;
        logic [8:0] addr;
        logic [7:0] sum;
        sltlog_test_s pend;
        sltlog_cmd_s cmd;
        logic [7:0] rdData;
        logic rdValid;
        logic idle;
        logic irq;
        sltlog_beat_s beat;
    } sltlog_core_s;

    logic [7:0] mem [`SLT_SECTOR_BYTES];
    sltlog_core_s q, d;
    logic memWe;
    logic [8:0] memAddr;
    logic [7:0] memWd, memRd, popData;
    logic popValid, popReady, popFire;
    logic [4:0] nextIdx;

    sltlog_fifo #(.WIDTH(8), .DEPTH(`SLT_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .inData(wrData),
        .inValid(wrValid),
        .inReady(wrReady),
        .outData(popData),
        .outValid(popValid),
        .outReady(popReady)
    );

    function automatic logic [8:0] descBase(input logic [4:0] slot);
        // slot n starts at 4 + 26*(n-1)
        descBase = 9'(`SLT_DESC_BASE + `SLT_DESC_LEN * (int'(slot) - 1));
    endfunction : descBase

    function automatic logic [7:0] descByte(input sltlog_test_s t,
                                            input logic [4:0] k);
        logic [47:0] lba;
        lba = t.is48 ? t.failLba : {20'h00000, t.failLba[27:0]};
        case (k)
            5'h00: descByte = t.lbaLow;
            5'h01: descByte = t.status;
            5'h02: descByte = t.lifeHours[7:0];
            5'h03: descByte = t.lifeHours[15:8];
            5'h04: descByte = t.checkpoint;
            5'h05: descByte = lba[7:0];
            5'h06: descByte = lba[15:8];
            5'h07: descByte = lba[23:16];
            5'h08: descByte = lba[31:24];
            5'h09: descByte = lba[39:32];
            5'h0a: descByte = lba[47:40];
            default: descByte = 8'h00;
        endcase
    endfunction : descByte

    assign nextIdx = (q.idx == 5'(`SLT_NUM_DESC)) ? 5'h01 : q.idx + 5'h01;
    assign memRd = mem[q.addr];
    assign popFire = popValid & popReady;

    always_comb begin
        d = q;
        memWe = 1'b0;
        memAddr = q.addr;
        memWd = 8'h00;
        popReady = 1'b0;
        d.rdValid = 1'b0;
        d.irq = 1'b0;
        d.beat.valid = 1'b0;
        case (q.st)
            ST_INIT: begin
                memWe = 1'b1;
                memWd = (q.addr == 9'(`SLT_REV_ADDR)) ? `SLT_REV_VALUE : 8'h00;
                d.addr = q.addr + 9'h001;
                if (q.addr == 9'(`SLT_LAST_SUM_ADDR)) begin
                    d.st = ST_SUM;
                    d.addr = 9'h000;
                    d.sum = 8'h00;
                end
            end
            ST_IDLE: begin
                if (testValid) begin
                    d.pend = testInfo;
                    d.idx = nextIdx;
                    d.addr = descBase(nextIdx);
                    d.byteCnt = 10'h000;
                    d.st = ST_DESC;
                end else if (cmdValid
                        && cmdInfo.opcode == `SLT_OP_WRITE_LOG) begin
                    d.cmd = cmdInfo;
                    d.sector = 16'h0000;
                    d.byteCnt = 10'h000;
                    if (cmdInfo.secCount != 16'h0000) begin
                        d.st = ST_WLOG;
                    end
                end else if (rdEn) begin
                    d.rdData = mem[rdAddr];
                    d.rdValid = 1'b1;
                end
            end
            ST_DESC: begin
                memWe = 1'b1;
                memWd = descByte(q.pend, q.byteCnt[4:0]);
                d.addr = q.addr + 9'h001;
                d.byteCnt = q.byteCnt + 10'h001;
                if (q.byteCnt == 10'(`SLT_DESC_LEN - 1)) begin
                    d.st = ST_HDR;
                    d.byteCnt = 10'h000;
                end
            end
            ST_HDR: begin
                memWe = 1'b1;
                memAddr = q.byteCnt[0] ? 9'(`SLT_IDX_HI_ADDR)
                                       : 9'(`SLT_IDX_LO_ADDR);
                memWd = q.byteCnt[0] ? 8'h00 : {3'h0, q.idx};
                d.byteCnt = 10'h001;
                if (q.byteCnt[0]) begin
                    d.st = ST_SUM;
                    d.addr = 9'h000;
                    d.sum = 8'h00;
                    d.byteCnt = 10'h000;
                end
            end
            ST_SUM: begin
                d.sum = q.sum + memRd;
                d.addr = q.addr + 9'h001;
                if (q.addr == 9'(`SLT_LAST_SUM_ADDR)) begin
                    d.st = ST_CSUM;
                end
            end
            ST_CSUM: begin
                memWe = 1'b1;
                memAddr = 9'(`SLT_CSUM_ADDR);
                memWd = ~q.sum + 8'h01;
                d.st = ST_IDLE;
            end
            ST_WLOG: begin
                popReady = 1'b1;
                if (popFire) begin
                    // pass sector bytes to log storage
                    d.beat.valid = 1'b1;
                    d.beat.logAddr = q.cmd.logAddr;
                    d.beat.sector = q.cmd.secOffset + q.sector;
                    d.beat.byteIdx = q.byteCnt[8:0];
                    d.beat.data = popData;
                    d.byteCnt = q.byteCnt + 10'h001;
                    if (q.byteCnt == 10'(`SLT_SECTOR_BYTES - 1)) begin
                        d.irq = 1'b1;
                        d.byteCnt = 10'h000;
                        d.sector = q.sector + 16'h0001;
                        if (q.sector + 16'h0001 == q.cmd.secCount) begin
                            d.st = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                d.st = ST_INIT;
                d.addr = 9'h000;
            end
        endcase
        d.idle = (d.st == ST_IDLE);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            q <= '0;
            q.st <= ST_INIT;
            q.idx <= `SLT_IDX_RESET;
        end else begin
            q <= d;
        end
        if (memWe) begin
            mem[memAddr] <= memWd;
        end
    end

    assign rdData_q = q.rdData;
    assign rdValid_q = q.rdValid;
    assign idle_q = q.idle;
    assign irq_q = q.irq;
    assign beat_q = q.beat;

    function automatic logic [7:0] sectorSum();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < `SLT_SECTOR_BYTES; i++) begin
            s = s + mem[i];
        end
        sectorSum = s;
    endfunction : sectorSum

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_test_accept;
        q.st == ST_IDLE && testValid;
    endsequence

    sequence s_desc_start;
        q.st == ST_DESC && q.byteCnt == 10'h000;
    endsequence

    a_rev_byte_const: assert property (q.idle |-> mem[0] == 8'h01)
        else $error("revision byte is not 01h");
    a_index_range: assert property (q.idx <= 5'h12)
        else $error("descriptor index above 18");
    a_index_wrap: assert property (s_test_accept |=>
        q.idx == (($past(q.idx) == 5'h12) ? 5'h01 : $past(q.idx) + 5'h01))
        else $error("descriptor index did not advance or wrap");
    a_entry_lba_low: assert property (s_desc_start |->
        memWe && memAddr == descBase(q.idx) && memWd == q.pend.lbaLow)
        else $error("entry does not open with lba low at slot base");
    a_entry_end: assert property ((q.st == ST_DESC
        && q.byteCnt == 10'h019) |-> memAddr <= 9'h1f1)
        else $error("descriptor ran past byte 497");
    a_hdr_index: assert property (q.idle |->
        mem[2] == {3'h0, q.idx} && mem[3] == 8'h00)
        else $error("header index bytes disagree with index");
    a_sector_sum: assert property (q.idle |-> sectorSum() == 8'h00)
        else $error("sector bytes do not sum to zero");
    a_update_bound: assert property (s_test_accept |->
        ##[540:545] q.st == ST_IDLE)
        else $error("self-test update did not finish in time");
    a_block_irq: assert property ($rose(irq_q) |->
        $past(q.byteCnt) == 10'h1ff && $past(popFire))
        else $error("interrupt not tied to end of a 512-byte block");
endmodule : sltlog_top
`default_nettype wire

/* File: sim/sltlog_host.sv */
// far-side host model pushing write-log sector bytes into the block
`timescale 1ns/1ns
`default_nettype none
module sltlog_host (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic [15:0] total,
    output logic [7:0] wrData,
    output logic wrValid,
    input wire logic wrReady,
    output logic [15:0] sentCnt_q
);
    logic [15:0] nxt;
    // number of the byte offered next once the current one is taken
    assign nxt = sentCnt_q + {15'h0000, wrValid};
    always @(posedge core_clk) begin
        if (!nrst) begin
            sentCnt_q <= 16'h0000;
            wrValid <= 1'b0;
            wrData <= 8'h00;
        end else if (!wrValid || wrReady) begin
            sentCnt_q <= nxt;
            if (nxt < total && !stall) begin
                wrValid <= 1'b1;
                wrData <= nxt[7:0] ^ nxt[15:8] ^ 8'h5a;
            end else begin
                // released line inverts its byte on every cycle it stays released
                wrValid <= 1'b0;
                wrData <= ~wrData;
            end
        end
    end
endmodule : sltlog_host
`default_nettype wire

/* File: sim/sltlog_top_test.sv */
// self-checking bench of the self-test log builder
`timescale 1ns/1ns
`default_nettype none
module sltlog_top_test;
    import sltlog_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic testValid = 1'b0;
    logic cmdValid = 1'b0;
    logic rdEn = 1'b0;
    logic stall = 1'b1;
    logic [8:0] rdAddr = 9'h000;
    logic [15:0] total = 16'h0000;
    sltlog_test_s testInfo = '0;
    sltlog_cmd_s cmdInfo = '0;
    logic [7:0] wrData, rdData_q;
    logic wrValid, wrReady, rdValid_q, idle_q, irq_q;
    logic [15:0] sentCnt;
    sltlog_beat_s beat_q;
    logic [7:0] expImg [512];
    logic [31:0] rng;
    logic [7:0] curLog;
    logic [15:0] curOff;
    int miscompares = 0;
    int nTests = 0;
    int curIdx = 0;
    int beatCnt = 0;
    int irqCnt = 0;

    always #4 core_clk = ~core_clk;

    sltlog_top dut (.core_clk(core_clk), .nrst(nrst), .testValid(testValid),
        .testInfo(testInfo), .cmdValid(cmdValid), .cmdInfo(cmdInfo),
        .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady), .rdEn(rdEn),
        .rdAddr(rdAddr), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
        .idle_q(idle_q), .irq_q(irq_q), .beat_q(beat_q));
    sltlog_host host (.core_clk(core_clk), .nrst(nrst), .stall(stall),
        .total(total), .wrData(wrData), .wrValid(wrValid),
        .wrReady(wrReady), .sentCnt_q(sentCnt));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xs

    function automatic logic [7:0] descByte(input sltlog_test_s t,
            input int k);
        logic [47:0] f;
        f = t.is48 ? t.failLba : {20'h00000, t.failLba[27:0]};
        case (k)
            0: return t.lbaLow;
            1: return t.status;
            2: return t.lifeHours[7:0];
            3: return t.lifeHours[15:8];
            4: return t.checkpoint;
            5, 6, 7, 8, 9, 10: return f[8*(k-5) +: 8];
            default: return 8'h00;
        endcase
    endfunction : descByte

    task automatic final_report();
        if (miscompares == 0 && nTests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [47:0] got, input logic [47:0] want,
            input string what);
        nTests++;
        if (got !== want) begin
            miscompares++;
            $display("BAD t=%0t %s got %h want %h", $time, what, got, want);
        end
    endtask : check

    task automatic waitIdle(input int lim);
        int i;
        for (i = 0; i < lim && idle_q !== 1'b1; i++) @(negedge core_clk);
        if (idle_q !== 1'b1) begin
            miscompares++;
            $display("BAD t=%0t idle wait ran out", $time);
            final_report();
        end
    endtask : waitIdle

    task automatic sumFix();
        logic [7:0] s;
        int a;
        s = 8'h00;
        for (a = 0; a < 511; a++) s += expImg[a];
        expImg[511] = -s;
    endtask : sumFix

    task automatic readSector();
        logic [7:0] s;
        int a;
        s = 8'h00;
        waitIdle(2000);
        rdEn = 1'b1;
        rdAddr = 9'h000;
        for (a = 0; a < 512; a++) begin
            @(negedge core_clk);
            check(48'(rdValid_q), 48'h1, "read strobe");
            check(48'(rdData_q), 48'(expImg[a]),
                "sector byte");
            s += rdData_q;
            if (a < 511) rdAddr = 9'(a + 1);
            else rdEn = 1'b0;
        end
        check(48'(s), 48'h0, "sector sum");
    endtask : readSector

    task automatic addTest(input sltlog_test_s t);
        int k;
        int b;
        waitIdle(2000);
        testInfo = t;
        testValid = 1'b1;
        @(negedge core_clk);
        testValid = 1'b0;
        check(48'(idle_q), 48'h0, "busy after test");
        rdEn = 1'b1;
        rdAddr = 9'h002;
        @(negedge core_clk);
        rdEn = 1'b0;
        check(48'(rdValid_q), 48'h0, "read while busy");
        curIdx = (curIdx == 18) ? 1 : curIdx + 1;
        b = 4 + 26 * (curIdx - 1);
        for (k = 0; k < 26; k++) expImg[b+k] = descByte(t, k);
        expImg[2] = 8'(curIdx);
        sumFix();
        waitIdle(600);
    endtask : addTest

    task automatic runCmd(input logic [7:0] op, input logic [15:0] cnt);
        cmdInfo = '{op, curLog, curOff, cnt};
        cmdValid = 1'b1;
        @(negedge core_clk);
        cmdValid = 1'b0;
    endtask : runCmd

    always @(negedge core_clk) begin
        if (beat_q.valid === 1'b1) begin
            check(48'(beat_q), 48'({1'b1, curLog, 16'(curOff + beatCnt / 512),
                9'(beatCnt % 512), 8'(beatCnt ^ (beatCnt >> 8) ^ 8'h5a)}),
                "beat");
            beatCnt++;
        end
        if (irq_q === 1'b1) begin
            irqCnt++;
            check(48'(beat_q.byteIdx), 48'h1ff, "irq at block end");
        end
    end

    initial begin
        sltlog_test_s t;
        int n;
        int i;
        rng = 32'hfe3f;
        for (i = 0; i < 512; i++) expImg[i] = 8'h00;
        expImg[0] = 8'h01;
        sumFix();
        curLog = 8'h00;
        curOff = 16'h0000;
        repeat (6) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        check(48'(wrReady), 48'h1, "fifo ready after reset");
        readSector();
        for (n = 0; n < 20; n++) begin
            rng = xs(rng);
            t.lbaLow = rng[7:0];
            t.status = rng[15:8];
            t.lifeHours = rng[31:16];
            rng = xs(rng);
            t.checkpoint = rng[7:0];
            t.is48 = rng[8];
            t.failLba = {rng[31:16], xs(rng)};
            rng = xs(rng);
            if (n == 1) begin
                t.failLba = 48'hffffffffffff;
                t.is48 = 1'b0;
            end
            addTest(t);
            if (n == 2 || n == 17 || n == 19) readSector();
        end
        rng = xs(rng);
        curLog = rng[7:0];
        curOff = rng[31:16];
        total = 16'h0400;
        stall = 1'b0;
        repeat (60) @(negedge core_clk);
        check(48'(wrReady), 48'h0, "fifo full");
        check(48'(sentCnt), 48'd32, "fifo depth");
        runCmd(8'h2f, 16'h0002);
        repeat (3) @(negedge core_clk);
        check(48'(idle_q), 48'h1, "other opcode ignored");
        runCmd(8'h3f, 16'h0000);
        repeat (3) @(negedge core_clk);
        check(48'(idle_q), 48'h1, "zero count");
        check(48'(beatCnt), 48'h0, "no beats yet");
        runCmd(8'h3f, 16'h0002);
        for (i = 0; i < 6000; i++) begin
            if (idle_q === 1'b1 && beatCnt == 1024) break;
            rng = xs(rng);
            stall = (rng[1:0] == 2'b00);
            @(negedge core_clk);
        end
        if (i == 6000) begin
            miscompares++;
            $display("BAD t=%0t write log wait ran out", $time);
            final_report();
        end
        check(48'(beatCnt), 48'd1024, "beat count");
        check(48'(irqCnt), 48'd2, "irq count");
        stall = 1'b1;
        readSector();
        final_report();
    end
endmodule : sltlog_top_test
`default_nettype wire
